// File: core/fcd_pkg.sv
// Purpose: shared constants and types for the flash command sequencer
// Assumes: 250 MHz sys_clk_i, byte-wide flash with 19 address lines
// Notes: all times in ns, cycle counts derived from them
package fcd_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_ADDR_SETUP_NS = 10;
  localparam int T_WE_LOW_NS = 30;
  localparam int T_WE_HIGH_NS = 30;
  localparam int T_ACCESS_NS = 90;
  localparam int T_READ_REC_NS = 20;
  localparam int T_ABORT_NS = 10000;
  // least times, rounded up to whole cycles
  localparam logic [11:0] SETUP_CYC = 12'((T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] WE_LOW_CYC = 12'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] WE_HIGH_CYC = 12'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ACCESS_CYC = 12'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] READ_REC_CYC = 12'((T_READ_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ABORT_CYC = 12'((T_ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ***************************************************************
  // command addresses and codes
  // ***************************************************************
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [18:0] ADDR_ANY = 19'h00000;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_AUTOSEL = 8'h90;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_BYPASS = 8'h20;
  localparam logic [7:0] CODE_BYPASS_EXIT = 8'h00;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  // status bits watched while polling
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_FAIL = 5;
  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_RESET3, OP_AUTOSEL, OP_PROGRAM, OP_BYPASS, OP_BYPASS_PROG,
    OP_BYPASS_EXIT, OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_BLOCK_ADD, OP_SUSPEND, OP_RESUME, OP_POLL
  } fcd_op_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_WSET = 7'h02, ST_WLOW = 7'h04, ST_WREC = 7'h08,
    ST_RACC = 7'h10, ST_RREC = 7'h20, ST_WAIT = 7'h40
  } fcd_state_t;
  typedef struct packed {
    fcd_op_t op;
    logic [18:0] addr;
    logic [7:0] data;
  } fcd_cmd_t;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } fcd_wr_t;
endpackage

// File: core/fcd_host.sv
// Purpose: host-side sequencer that drives a byte-wide flash through its pins
// Assumes: flash inputs synchronous to sys_clk_i, one command at a time
// Notes: pin outputs all registered; dq is split into in/out/enable
// How it works
// - reset is F0 alone, or AA@555, 55@2AA, F0; clears our error flag.
// - auto select entry is AA@555, 55@2AA, 90@555.
// - program is AA@555, 55@2AA, A0@555, then value at target address.
// - bypass entry is AA@555, 55@2AA, 20@555.
// - bypass program is A0 anywhere, then value at target address.
// - bypass exit is 90 then 00, both anywhere.
// - chip erase is AA,55,80,AA,55 then 10 at 555.
// - block erase ends with 30 in the block; more blocks by repeating it.
// - erase suspend is one write of B0 anywhere.
// - erase resume is one write of 30, then status polling.
// - after program, chip erase or resume we poll status until done.
// - output enable held high through every bus write.
`timescale 1ns/1ns
module fcd_host (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // user command port
  input wire logic cmd_valid_i,
  input wire fcd_pkg::fcd_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic err_o,
  // flash pins
  output logic [18:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n_o
);
  // ***************************************************************
  // sequence tables
  // ***************************************************************
  // number of bus writes per operation
  function automatic logic [2:0] seq_len(input fcd_pkg::fcd_op_t op);
    case (op)
      fcd_pkg::OP_RESET, fcd_pkg::OP_BLOCK_ADD, fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME: seq_len = 3'h1;
      fcd_pkg::OP_BYPASS_PROG, fcd_pkg::OP_BYPASS_EXIT: seq_len = 3'h2;
      fcd_pkg::OP_RESET3, fcd_pkg::OP_AUTOSEL, fcd_pkg::OP_BYPASS: seq_len = 3'h3;
      fcd_pkg::OP_PROGRAM: seq_len = 3'h4;
      fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_BLOCK_ERASE: seq_len = 3'h6;
      default: seq_len = 3'h0;
    endcase
  endfunction

  // address and data of write i of an operation; unlock prefix by default
  function automatic fcd_pkg::fcd_wr_t seq_word(input fcd_pkg::fcd_cmd_t c, input logic [2:0] i);
    fcd_pkg::fcd_wr_t w;
    w = '{addr: fcd_pkg::ADDR_UNLOCK1, data: fcd_pkg::CODE_UNLOCK1};
    case (c.op)
      fcd_pkg::OP_RESET: w = '{addr: fcd_pkg::ADDR_ANY, data: fcd_pkg::CODE_RESET};
      fcd_pkg::OP_BLOCK_ADD: w = '{addr: c.addr, data: fcd_pkg::CODE_BLOCK_ERASE};
      fcd_pkg::OP_SUSPEND: w = '{addr: fcd_pkg::ADDR_ANY, data: fcd_pkg::CODE_SUSPEND};
      fcd_pkg::OP_RESUME: w = '{addr: fcd_pkg::ADDR_ANY, data: fcd_pkg::CODE_RESUME};
      fcd_pkg::OP_BYPASS_PROG: begin
        if (i == 3'h0) begin
          w = '{addr: fcd_pkg::ADDR_ANY, data: fcd_pkg::CODE_PROGRAM};
        end else begin
          w = '{addr: c.addr, data: c.data};
        end
      end
      fcd_pkg::OP_BYPASS_EXIT: begin
        w.addr = fcd_pkg::ADDR_ANY;
        w.data = (i == 3'h0) ? fcd_pkg::CODE_AUTOSEL : fcd_pkg::CODE_BYPASS_EXIT;
      end
      default: begin
        case (i)
          3'h1, 3'h4: w = '{addr: fcd_pkg::ADDR_UNLOCK2, data: fcd_pkg::CODE_UNLOCK2};
          3'h2: begin
            case (c.op)
              fcd_pkg::OP_RESET3: w = '{addr: fcd_pkg::ADDR_ANY, data: fcd_pkg::CODE_RESET};
              fcd_pkg::OP_AUTOSEL: w.data = fcd_pkg::CODE_AUTOSEL;
              fcd_pkg::OP_PROGRAM: w.data = fcd_pkg::CODE_PROGRAM;
              fcd_pkg::OP_BYPASS: w.data = fcd_pkg::CODE_BYPASS;
              default: w.data = fcd_pkg::CODE_ERASE_SETUP;
            endcase
          end
          3'h3: begin
            if (c.op == fcd_pkg::OP_PROGRAM) begin
              w = '{addr: c.addr, data: c.data};
            end
          end
          3'h5: begin
            if (c.op == fcd_pkg::OP_CHIP_ERASE) begin
              w.data = fcd_pkg::CODE_CHIP_ERASE;
            end else begin
              w = '{addr: c.addr, data: fcd_pkg::CODE_BLOCK_ERASE};
            end
          end
          default: ;
        endcase
      end
    endcase
    seq_word = w;
  endfunction

  // ***************************************************************
  // sequencer state
  // ***************************************************************
  fcd_pkg::fcd_state_t st_q, st_d;
  fcd_pkg::fcd_cmd_t cmd_q, cmd_d;
  logic [2:0] step_q, step_d;
  logic [11:0] cnt_q, cnt_d;
  logic poll_q, poll_d, first_q, first_d, tog_q, tog_d, fail_q, fail_d, more_q, more_d;
  logic err_q, err_d, done_q, done_d, ready_q, ready_d;
  logic [7:0] rdata_q, rdata_d;
  logic wants_poll, is_reset, last_write;

  // polling after commands that start the controller, block erase excepted; resets get abort wait
  assign wants_poll = cmd_q.op inside {fcd_pkg::OP_PROGRAM, fcd_pkg::OP_BYPASS_PROG,
                                       fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_RESUME};
  assign is_reset = cmd_q.op inside {fcd_pkg::OP_RESET, fcd_pkg::OP_RESET3};
  assign last_write = (step_q + 3'h1) == seq_len(cmd_q.op);

  // next-state logic; ready only in idle so busy commands cannot slip in
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    step_d = step_q;
    cnt_d = cnt_q + 12'h001;
    poll_d = poll_q;
    first_d = first_q;
    tog_d = tog_q;
    fail_d = fail_q;
    more_d = more_q;
    err_d = err_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    ready_d = 1'b0;
    case (st_q)
      fcd_pkg::ST_IDLE: begin
        ready_d = 1'b1;
        cnt_d = 12'h000;
        if (cmd_valid_i && ready_q) begin
          ready_d = 1'b0;
          cmd_d = cmd_i;
          step_d = 3'h0;
          first_d = 1'b1;
          fail_d = 1'b0;
          poll_d = (cmd_i.op == fcd_pkg::OP_POLL);
          st_d = (seq_len(cmd_i.op) == 3'h0) ? fcd_pkg::ST_RACC : fcd_pkg::ST_WSET;
        end
      end
      fcd_pkg::ST_WSET: begin
        if (cnt_q == fcd_pkg::SETUP_CYC - 12'h001) begin
          st_d = fcd_pkg::ST_WLOW;
          cnt_d = 12'h000;
        end
      end
      fcd_pkg::ST_WLOW: begin
        if (cnt_q == fcd_pkg::WE_LOW_CYC - 12'h001) begin
          st_d = fcd_pkg::ST_WREC;
          cnt_d = 12'h000;
        end
      end
      fcd_pkg::ST_WREC: begin
        if (cnt_q == fcd_pkg::WE_HIGH_CYC - 12'h001) begin
          cnt_d = 12'h000;
          step_d = step_q + 3'h1;
          if (!last_write) begin
            st_d = fcd_pkg::ST_WSET;
          end else if (wants_poll) begin
            poll_d = 1'b1;
            st_d = fcd_pkg::ST_RACC;
          end else if (is_reset) begin
            err_d = 1'b0;
            st_d = fcd_pkg::ST_WAIT;
          end else begin
            done_d = 1'b1;
            st_d = fcd_pkg::ST_IDLE;
          end
        end
      end
      fcd_pkg::ST_RACC: begin
        if (cnt_q == fcd_pkg::ACCESS_CYC - 12'h001) begin
          st_d = fcd_pkg::ST_RREC;
          cnt_d = 12'h000;
          rdata_d = flash_dq_i;
          first_d = 1'b0;
          tog_d = flash_dq_i[fcd_pkg::DQ_TOGGLE];
          fail_d = flash_dq_i[fcd_pkg::DQ_FAIL];
          // toggle bit still moving means the controller is busy
          more_d = poll_q && (first_q || (tog_q != flash_dq_i[fcd_pkg::DQ_TOGGLE]));
          if (poll_q && !first_q && (tog_q != flash_dq_i[fcd_pkg::DQ_TOGGLE]) && fail_q) begin
            err_d = 1'b1;
            more_d = 1'b0;
          end
        end
      end
      fcd_pkg::ST_RREC: begin
        if (cnt_q == fcd_pkg::READ_REC_CYC - 12'h001) begin
          cnt_d = 12'h000;
          if (more_q) begin
            st_d = fcd_pkg::ST_RACC;
          end else begin
            done_d = 1'b1;
            st_d = fcd_pkg::ST_IDLE;
          end
        end
      end
      fcd_pkg::ST_WAIT: begin
        if (cnt_q == fcd_pkg::ABORT_CYC - 12'h001) begin
          done_d = 1'b1;
          st_d = fcd_pkg::ST_IDLE;
        end
      end
      default: st_d = fcd_pkg::ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= fcd_pkg::ST_IDLE;
      cmd_q <= '0;
      step_q <= 3'h0;
      cnt_q <= 12'h000;
      poll_q <= 1'b0;
      first_q <= 1'b0;
      tog_q <= 1'b0;
      fail_q <= 1'b0;
      more_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      poll_q <= poll_d;
      first_q <= first_d;
      tog_q <= tog_d;
      fail_q <= fail_d;
      more_q <= more_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      ready_q <= ready_d;
    end
  end

  // ***************************************************************
  // pin drivers
  // ***************************************************************
  logic [18:0] addr_q, addr_d;
  logic [7:0] dq_q, dq_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dqoe_n_q, dqoe_n_d;
  fcd_pkg::fcd_wr_t word_d;

  // pins follow the next state; data held through the 8 recovery cycles past the strobe rise
  always_comb begin
    word_d = seq_word(cmd_d, step_d);
    ce_n_d = !(st_d inside {fcd_pkg::ST_WSET, fcd_pkg::ST_WLOW, fcd_pkg::ST_RACC});
    we_n_d = (st_d != fcd_pkg::ST_WLOW);
    oe_n_d = (st_d != fcd_pkg::ST_RACC);
    dqoe_n_d = !(st_d inside {fcd_pkg::ST_WSET, fcd_pkg::ST_WLOW, fcd_pkg::ST_WREC});
    dq_d = dqoe_n_d ? dq_q : word_d.data;
    addr_d = addr_q;
    if (st_d inside {fcd_pkg::ST_WSET, fcd_pkg::ST_WLOW}) begin
      addr_d = word_d.addr;
    end else if (st_d == fcd_pkg::ST_RACC) begin
      addr_d = poll_d ? fcd_pkg::ADDR_ANY : cmd_d.addr;
    end
  end

  // pin registers; bus idles with every strobe high
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= 19'h00000;
      dq_q <= 8'h00;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dqoe_n_q <= 1'b1;
    end else begin
      addr_q <= addr_d;
      dq_q <= dq_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dqoe_n_q <= dqoe_n_d;
    end
  end

  assign flash_addr_o = addr_q;
  assign flash_dq_o = dq_q;
  assign flash_ce_n_o = ce_n_q;
  assign flash_oe_n_o = oe_n_q;
  assign flash_we_n_o = we_n_q;
  assign flash_dq_oe_n_o = dqoe_n_q;
  assign cmd_ready_o = ready_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign err_o = err_q;

  // ***************************************************************
  // assertions
  // ***************************************************************
  logic wfall;
  // first cycle of the strobe-low phase; write enable follows the state register one to one
  assign wfall = (st_q == fcd_pkg::ST_WLOW) && (cnt_q == 12'h000);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_oe_during_write: assert property (!we_n_q |-> oe_n_q && !ce_n_q && !dqoe_n_q)
    else $error("output enable low during a write");
  a_unlock_first: assert property (wfall && step_q == 3'h0 && cmd_q.op inside {fcd_pkg::OP_RESET3,
    fcd_pkg::OP_AUTOSEL, fcd_pkg::OP_PROGRAM, fcd_pkg::OP_BYPASS, fcd_pkg::OP_CHIP_ERASE}
    |-> addr_q[10:0] == 11'h555 && dq_q == 8'hAA)
    else $error("first unlock write wrong");
  a_unlock_second: assert property (wfall && (step_q == 3'h1 || step_q == 3'h4) && seq_len(cmd_q.op) > 3'h2
    |-> addr_q[10:0] == 11'h2AA && dq_q == 8'h55)
    else $error("second unlock write wrong");
  a_reset_single: assert property (wfall && cmd_q.op == fcd_pkg::OP_RESET |-> dq_q == 8'hF0)
    else $error("reset code wrong");
  a_third_code: assert property (wfall && step_q == 3'h2 && cmd_q.op == fcd_pkg::OP_AUTOSEL
    |-> dq_q == 8'h90 && addr_q[10:0] == 11'h555)
    else $error("auto select code wrong");
  a_program_data: assert property (wfall && step_q == 3'h3 && cmd_q.op == fcd_pkg::OP_PROGRAM
    |-> dq_q == cmd_q.data && addr_q == cmd_q.addr && $past(dq_q, 19) == 8'hA0)
    else $error("program data write wrong");
  a_bypass_entry: assert property (wfall && step_q == 3'h2 && cmd_q.op == fcd_pkg::OP_BYPASS
    |-> dq_q == 8'h20)
    else $error("bypass entry code wrong");
  a_bypass_prog: assert property (wfall && step_q == 3'h0 && cmd_q.op == fcd_pkg::OP_BYPASS_PROG
    |-> dq_q == 8'hA0 ##20 (!we_n_q && dq_q == cmd_q.data))
    else $error("bypass program sequence wrong");
  a_bypass_exit: assert property (wfall && cmd_q.op == fcd_pkg::OP_BYPASS_EXIT
    |-> dq_q == ((step_q == 3'h0) ? 8'h90 : 8'h00))
    else $error("bypass exit code wrong");
  a_erase_last: assert property (wfall && step_q == 3'h5
    |-> dq_q == ((cmd_q.op == fcd_pkg::OP_CHIP_ERASE) ? 8'h10 : 8'h30))
    else $error("erase final code wrong");
  a_suspend_resume: assert property (wfall && cmd_q.op inside {fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME}
    |-> dq_q == ((cmd_q.op == fcd_pkg::OP_SUSPEND) ? 8'hB0 : 8'h30))
    else $error("suspend or resume code wrong");
  a_poll_follows: assert property ($rose(we_n_q) && last_write && wants_poll
    |-> ##[8:9] !oe_n_q)
    else $error("no status poll after controller start");
  a_abort_wait: assert property ($rose(st_q == fcd_pkg::ST_WAIT) |-> (st_q == fcd_pkg::ST_WAIT)[*8])
    else $error("abort wait cut short");
  a_ready_idle: assert property (cmd_ready_o |-> st_q == fcd_pkg::ST_IDLE && !done_o)
    else $error("ready while busy");
  c_program: cover property (done_q && cmd_q.op == fcd_pkg::OP_PROGRAM);
  c_chip_erase: cover property (done_q && cmd_q.op == fcd_pkg::OP_CHIP_ERASE);
  c_error: cover property ($rose(err_q));
  c_bypass_prog: cover property (done_q && cmd_q.op == fcd_pkg::OP_BYPASS_PROG);
endmodule

// File: tb/fcd_flash_model.sv
// Purpose: behavioural byte-wide flash that answers the host sequencer
// Assumes: strobes active low; the host drives dq only while it writes
// Notes: clockless; a released data bus shows the inverse of the last byte
`timescale 1ns/1ns
module fcd_flash_model #(
  parameter int PROG_NS = 1200,
  parameter int ERASE_NS = 3000,
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID = 8'hC3 // arbitrary value
) (
  // bus strobes and address
  input wire logic [18:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  // data
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0] mem [0:524287];
  logic [7:0] prot = 8'h00;
  logic [7:0] eblk = 8'h00;
  logic [7:0] last = 8'h00;
  logic [18:0] a_q = '0;
  int step = 0;
  int gen = 0;
  int acc_ns = 5;
  int n_bad = 0;
  bit asel, byp, prg, busy, fail, susp, tgl, wact;
  time abort_t = 0;
  fcd_pkg::fcd_wr_t wlog [$];

  // array starts erased, bus idles at a drifting value
  initial begin
    for (int k = 0; k < 524288; k++) mem[k] = 8'hFF;
    dq_o = 8'h00;
  end

  // controller busy timer; a stale timer is ignored through gen
  task automatic run(input int ns, input bit erase);
    int g;
    gen++;
    g = gen;
    busy = 1;
    fork
      begin
        #(ns);
        if (g == gen && !fail) begin
          busy = 0;
          if (erase) for (int k = 0; k < 524288; k++) if (eblk[k[18:16]]) mem[k] = 8'hFF;
          eblk = 8'h00;
        end
      end
    join_none
  endtask

  // a broken sequence drops back to read mode
  task automatic go(input bit ok, input int n);
    step = ok ? n : 0;
    if (!ok) asel = 0;
  endtask

  // command decoder, one call per completed bus write
  task automatic wr(input logic [18:0] fa, input logic [7:0] d);
    logic [10:0] a;
    a = fa[10:0];
    wlog.push_back({fa, d});
    if (prg) begin
      prg = 0;
      if (!prot[fa[18:16]]) begin
        fail = |(d & ~mem[fa]);
        mem[fa] = mem[fa] & d;
        run(PROG_NS, 0);
      end
    end else if (busy && eblk == 8'h00 && !fail) begin
      step = 0;
    end else if (d == 8'hF0) begin
      if (busy || fail) abort_t = $time + 10000;
      busy = 0;
      fail = 0;
      gen++;
      eblk = 8'h00;
      susp = 0;
      go(0, 0);
    end else if (busy) begin
      if (d == 8'hB0) begin
        susp = 1;
        busy = 0;
        gen++;
      end else if (d == 8'h30) eblk[fa[18:16]] = !prot[fa[18:16]];
    end else if (susp && d == 8'h30) begin
      susp = 0;
      run(ERASE_NS, 1);
    end else case (step)
      0: if (byp && d == 8'hA0) prg = 1;
         else if (byp && d == 8'h90) step = 6;
         else go(a == 11'h555 && d == 8'hAA, 1);
      1: go(a == 11'h2AA && d == 8'h55, 2);
      2: if (a == 11'h555 && d inside {8'h90, 8'hA0, 8'h20}) begin
           asel = (d == 8'h90);
           prg = (d == 8'hA0);
           byp = byp || (d == 8'h20);
           step = 0;
         end else go(a == 11'h555 && d == 8'h80, 3);
      3: go(a == 11'h555 && d == 8'hAA, 4);
      4: go(a == 11'h2AA && d == 8'h55, 5);
      5: if (d == 8'h30 || (a == 11'h555 && d == 8'h10)) begin
           eblk = (d == 8'h10 ? 8'hFF : 8'h01 << fa[18:16]) & ~prot;
           step = 0;
           run(ERASE_NS, 1);
         end else go(0, 0);
      default: begin
        byp = (d != 8'h00);
        step = 0;
      end
    endcase
  endtask

  // address on the later falling strobe
  always @(negedge we_n_i or negedge ce_n_i) begin
    #1;
    if (!we_n_i && !ce_n_i) begin
      a_q = addr_i;
      wact = 1;
      if (oe_n_i !== 1'b1) n_bad++;
    end
  end

  // data on the earlier rising strobe; wact stops a double take
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (wact) begin
      wact = 0;
      if (oe_n_i !== 1'b1) n_bad++;
      wr(a_q, dq_i);
    end
  end

  // read answer after the access delay, which a scenario may stretch
  always @(negedge oe_n_i) begin
    logic [7:0] v;
    #1;
    if (!ce_n_i) begin
      if ($time < abort_t) v = ~last;
      else if (busy || fail || (susp && eblk[addr_i[18:16]])) begin
        if (busy || fail) tgl = ~tgl;
        v = {1'b0, tgl, fail, 5'h00};
      end else if (asel) begin
        v = addr_i[1] ? {7'h00, ~addr_i[0] & prot[addr_i[18:16]]} : (addr_i[0] ? PART_ID : MAKER_ID);
      end else v = mem[addr_i];
      last = v;
      dq_o <= #(acc_ns) v;
    end
  end

  // released bus does not keep the last byte
  always @(posedge oe_n_i or posedge ce_n_i) dq_o = ~last;
endmodule

// File: tb/fcd_host_tb.sv
// Purpose: self-checking bench for the host flash sequencer
// Assumes: one command in flight, inputs changed on the falling clock edge
// Notes: write sequences are judged from the flash model's write log
`timescale 1ns/1ns
module fcd_host_tb;
  // ***************************************************************
  // signals and instances
  // ***************************************************************
  localparam logic [26:0] U1 = {19'h00555, 8'hAA};
  localparam logic [26:0] U2 = {19'h002AA, 8'h55};
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  fcd_pkg::fcd_cmd_t cmd_i = '0;
  logic cmd_ready_o, done_o, err_o, ce_n, oe_n, we_n, dq_oe_n;
  logic [7:0] rdata_o, dq_host, dq_flash, dq_bus;
  logic [18:0] addr;
  int n_mismatch = 0;
  int checked = 0;
  int lat = 0;

  // shared data bus: host wins only while its enable is low
  assign dq_bus = dq_oe_n ? dq_flash : dq_host;

  fcd_host dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o), .err_o(err_o), .flash_addr_o(addr),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_i(dq_bus),
    .flash_dq_o(dq_host), .flash_dq_oe_n_o(dq_oe_n));
  fcd_flash_model flash (.addr_i(addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_bus),
    .dq_o(dq_flash));

  // free-running 250 MHz clock
  initial forever #2 sys_clk_i = ~sys_clk_i;

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // offer one command, then wait for done; bounded so a hang ends the run
  task automatic issue(input fcd_pkg::fcd_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    flash.wlog.delete();
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b1;
    cmd_i = {op, a, d};
    for (n = 0; n < 100 && cmd_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    for (lat = 0; lat < 20000 && done_o !== 1'b1; lat++) @(negedge sys_clk_i);
    if (n == 100 || lat == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic expect_log(input fcd_pkg::fcd_wr_t e [$]);
    check(32'(flash.wlog.size()), 32'(e.size()));
    foreach (e[i]) if (i < flash.wlog.size()) check(32'(flash.wlog[i]), 32'(e[i]));
  endtask

  task automatic rd(input logic [18:0] a, input logic [7:0] e);
    issue(fcd_pkg::OP_READ, a, 8'h00);
    check(32'(rdata_o), 32'(e));
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic s_reset();
    issue(fcd_pkg::OP_RESET, 19'h00000, 8'h00);
    expect_log('{{19'h00000, 8'hF0}});
    check(32'(lat >= 2500), 32'd1);
    issue(fcd_pkg::OP_RESET3, 19'h00000, 8'h00);
    expect_log('{U1, U2, {19'h00000, 8'hF0}});
    rd(19'h4ABCD, 8'hFF);
  endtask

  // high address bits set on purpose: they must not matter for the maker ID read, and pick the block for the protect reads
  task automatic s_autosel();
    logic [18:0] ra [4] = '{19'h7FFFC, 19'h00001, 19'h50002, 19'h4FFFE};
    logic [7:0] rv [4] = '{8'h5A, 8'hC3, 8'h01, 8'h00};
    issue(fcd_pkg::OP_AUTOSEL, 19'h00000, 8'h00);
    expect_log('{U1, U2, {19'h00555, 8'h90}});
    foreach (ra[i]) rd(ra[i], rv[i]);
    issue(fcd_pkg::OP_RESET3, 19'h00000, 8'h00);
  endtask

  // slow flash answers; one-over-zero error; protected target
  task automatic s_program();
    flash.acc_ns = 80;
    issue(fcd_pkg::OP_PROGRAM, 19'h12345, 8'h3C);
    expect_log('{U1, U2, {19'h00555, 8'hA0}, {19'h12345, 8'h3C}});
    check(32'(err_o), 32'd0);
    rd(19'h12345, 8'h3C);
    issue(fcd_pkg::OP_PROGRAM, 19'h12345, 8'hC3);
    check(32'(err_o), 32'd1);
    issue(fcd_pkg::OP_RESET, 19'h00000, 8'h00);
    check(32'(err_o), 32'd0);
    rd(19'h12345, 8'h00);
    issue(fcd_pkg::OP_PROGRAM, 19'h51000, 8'h00);
    check(32'(err_o), 32'd0);
    rd(19'h51000, 8'hFF);
    flash.acc_ns = 5;
  endtask

  task automatic s_bypass();
    issue(fcd_pkg::OP_BYPASS, 19'h00000, 8'h00);
    expect_log('{U1, U2, {19'h00555, 8'h20}});
    issue(fcd_pkg::OP_BYPASS_PROG, 19'h01000, 8'h5A);
    expect_log('{{19'h00000, 8'hA0}, {19'h01000, 8'h5A}});
    rd(19'h01000, 8'h5A);
    issue(fcd_pkg::OP_BYPASS_EXIT, 19'h00000, 8'h00);
    expect_log('{{19'h00000, 8'h90}, {19'h00000, 8'h00}});
    rd(19'h01001, 8'hFF);
  endtask

  // chip erase, then a two-block erase suspended and resumed mid-way
  task automatic s_erase();
    issue(fcd_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00);
    expect_log('{U1, U2, {19'h00555, 8'h80}, U1, U2, {19'h00555, 8'h10}});
    rd(19'h12345, 8'hFF);
    issue(fcd_pkg::OP_PROGRAM, 19'h01000, 8'h5A);
    issue(fcd_pkg::OP_PROGRAM, 19'h20010, 8'h00);
    issue(fcd_pkg::OP_BLOCK_ERASE, 19'h20000, 8'h00);
    expect_log('{U1, U2, {19'h00555, 8'h80}, U1, U2, {19'h20000, 8'h30}});
    issue(fcd_pkg::OP_BLOCK_ADD, 19'h30000, 8'h00);
    expect_log('{{19'h30000, 8'h30}});
    issue(fcd_pkg::OP_SUSPEND, 19'h00000, 8'h00);
    expect_log('{{19'h00000, 8'hB0}});
    rd(19'h01000, 8'h5A);
    issue(fcd_pkg::OP_RESUME, 19'h00000, 8'h00);
    expect_log('{{19'h00000, 8'h30}});
    rd(19'h20010, 8'hFF);
    // block erase without its own poll: a separate poll command waits it out
    issue(fcd_pkg::OP_PROGRAM, 19'h60000, 8'h00);
    issue(fcd_pkg::OP_BLOCK_ERASE, 19'h60000, 8'h00);
    issue(fcd_pkg::OP_POLL, 19'h00000, 8'h00);
    check(32'(err_o), 32'd0);
    rd(19'h60000, 8'hFF);
    issue(fcd_pkg::OP_BLOCK_ERASE, 19'h60000, 8'h00);
    issue(fcd_pkg::OP_RESET, 19'h00000, 8'h00);
    check(32'(lat >= 2500), 32'd1);
    rd(19'h01000, 8'h5A);
  endtask

  // reset, scenarios, verdict
  initial begin
    flash.prot = 8'h20;
    repeat (10) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    s_reset();
    s_autosel();
    s_program();
    s_bypass();
    s_erase();
    check(32'(flash.n_bad), 32'd0);
    tally_and_finish();
  end
endmodule
